/* bench/cbc_host_model.sv */
// host model driving the register port of the configuration bank
`timescale 1ns/1ps
`default_nettype none
module cbc_host_model (
   // clock
   input  wire logic       clk,
   // register port
   output logic      [7:0] addr,
   output logic            wr,
   output logic      [7:0] wdata,
   input  wire logic [7:0] rdata
);
   initial begin
      addr = 8'h00;
      wr = 1'b0;
      wdata = 8'h00;
   end
   // one strobe per byte; data line inverted once released
   task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= (a == 8'h0A) ? (d & 8'h7F) : d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~d;
   endtask
   // data registered one edge after the address, taken one edge later
   task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      @(posedge clk);
      @(posedge clk);
      d = rdata;
   endtask
endmodule
`default_nettype wire

/* bench/tb_cbc_regs.sv */
// self-checking bench of the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_cbc_regs;
   logic                      mclk;
   logic                      rstn;
   logic [7:0]                reg_addr;
   logic                      reg_wr;
   logic [7:0]                reg_wdata;
   logic [7:0]                reg_rdata;
   logic [3:0]                out_en_ctrl;
   logic [3:0][1:0]           factory_imp;
   logic [3:0]                oe_n_pin;
   logic                      powergood_pin;
   logic [4:0]                readback_count;
   logic                      keep_config;
   logic [3:0][1:0]           impedance_sel;
   logic [4:0]                pullup_en;
   logic [4:0]                pulldn_en;
   logic                      powered_up;
   cbc_pkg::cbc_drive_t [3:0] drive;
   int                        mismatches;
   int                        check_count;
   logic [7:0]                sh [32];
   logic [7:0]                seed;
   logic [7:0]                a;
   logic [7:0]                d;

   cbc_regs cbc_regs_i (
      .MCLK(mclk), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
      .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
      .OUT_EN_CTRL(out_en_ctrl), .FACTORY_IMP(factory_imp),
      .OE_N_PIN(oe_n_pin), .POWERGOOD_PIN(powergood_pin),
      .READBACK_COUNT(readback_count), .KEEP_CONFIG(keep_config),
      .IMPEDANCE_SEL(impedance_sel), .PULLUP_EN(pullup_en),
      .PULLDN_EN(pulldn_en), .POWERED_UP(powered_up), .DRIVE(drive)
   );
   cbc_host_model cbc_host_model_i (
      .clk(mclk), .addr(reg_addr), .wr(reg_wr), .wdata(reg_wdata),
      .rdata(reg_rdata)
   );

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   function automatic logic [3:0] exp_drive(input logic en,
                                            input logic [1:0] lvl);
      if (en)
         return 4'h8;
      case (lvl)
         cbc_pkg::LEVEL_LOW_LOW:  return 4'h0;
         cbc_pkg::LEVEL_HIZ:      return 4'h4;
         cbc_pkg::LEVEL_HIGH_LOW: return 4'h2;
         default:                 return 4'h1;
      endcase
   endfunction

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // expected contents after reset or a clearing power down
   task automatic reset_shadow();
      logic [1:0] f;
      foreach (sh[i])
         sh[i] = 8'h00;
      sh[7] = {3'h0, cbc_pkg::COUNT_RST};
      sh[10] = {cbc_pkg::RSVD10_RST, cbc_pkg::KEEP_RST, 6'h00};
      sh[11] = {6'h00, cbc_pkg::LEVEL_RST};
      for (int i = 0; i < 4; i++) begin
         f = factory_imp[i];
         if (f == cbc_pkg::IMP_RSVD)
            f = cbc_pkg::IMP_100;
         sh[cbc_pkg::IMP_ADDR[i][4:0]][cbc_pkg::IMP_LSB[i] +: 2] = f;
      end
      for (int i = 0; i < 5; i++)
         sh[cbc_pkg::BIAS_ADDR[i][4:0]][cbc_pkg::BIAS_LSB[i] +: 2] =
            cbc_pkg::BIAS_RST[i];
      sh[16] = sh[16] | cbc_pkg::RSVD16_VAL;
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] dd);
      logic [7:0] m;
      m = (ad == cbc_pkg::REG_POWERDOWN_RETENTION) ? (dd & 8'h7F) : dd;
      cbc_host_model_i.write_byte(ad, dd);
      if (ad == cbc_pkg::REG_READBACK_LENGTH)
         sh[7] = {3'h0, m[4:0]};
      if (ad == cbc_pkg::REG_POWERDOWN_RETENTION)
         sh[10] = {m[7:6], 6'h00};
      if (ad == cbc_pkg::REG_DISABLED_OUTPUT_LEVEL)
         sh[11] = {6'h00, m[1:0]};
      for (int i = 0; i < 4; i++)
         if (ad == cbc_pkg::IMP_ADDR[i] &&
             m[cbc_pkg::IMP_LSB[i] +: 2] != cbc_pkg::IMP_RSVD)
            sh[ad[4:0]][cbc_pkg::IMP_LSB[i] +: 2] =
               m[cbc_pkg::IMP_LSB[i] +: 2];
      for (int i = 0; i < 5; i++)
         if (ad == cbc_pkg::BIAS_ADDR[i])
            sh[ad[4:0]][cbc_pkg::BIAS_LSB[i] +: 2] =
               m[cbc_pkg::BIAS_LSB[i] +: 2];
   endtask

   // every byte of the bank plus unmapped neighbours, then the field ports
   task automatic check_all();
      logic [1:0] e;
      logic [1:0] g;
      for (int i = 5; i < 20; i++) begin
         cbc_host_model_i.read_byte(8'(i), d);
         check(d, sh[i]);
      end
      check({3'h0, readback_count}, {3'h0, sh[7][4:0]});
      check({7'h0, keep_config}, {7'h0, sh[10][6]});
      for (int i = 0; i < 4; i++) begin
         e = sh[cbc_pkg::IMP_ADDR[i][4:0]][cbc_pkg::IMP_LSB[i] +: 2];
         check({6'h0, impedance_sel[i]}, {6'h0, e});
      end
      for (int i = 0; i < 5; i++) begin
         e = sh[cbc_pkg::BIAS_ADDR[i][4:0]][cbc_pkg::BIAS_LSB[i] +: 2];
         g = {pullup_en[i], pulldn_en[i]};
         check({6'h0, g}, {6'h0, e});
      end
   endtask

   task automatic check_drive(input logic en);
      logic [3:0] x;
      repeat (2) @(posedge mclk);
      x = exp_drive(en, sh[11][1:0]);
      for (int i = 0; i < 4; i++)
         check({4'h0, drive[i]}, {4'h0, x});
   endtask

   initial begin
      rstn = 1'b0;
      out_en_ctrl = 4'h0;
      oe_n_pin = 4'hF;
      powergood_pin = 1'b0;
      seed = 8'h0B;
      factory_imp = {cbc_pkg::IMP_85, cbc_pkg::IMP_33, cbc_pkg::IMP_RSVD,
                     seed[1:0]};
      mismatches = 0;
      check_count = 0;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      powergood_pin <= 1'b1;
      reset_shadow();
      check_all();
      // random bytes over the bank, reserved and unmapped places included
      repeat (60) begin
         seed = lfsr(seed);
         a = {3'h0, seed[4:0]};
         seed = lfsr(seed);
         wr(a, seed);
      end
      wr(8'h0C, 8'hFF);
      wr(8'h0D, 8'h3C);
      wr(8'h08, 8'hFF);
      wr(8'h11, 8'hA5);
      wr(8'h0C, 8'h44);
      wr(8'h0F, 8'h18);
      wr(8'h10, 8'h03);
      wr(8'h07, 8'hFF);
      check_all();
      // each disabled level, then all outputs enabled
      oe_n_pin <= 4'h0;
      for (int l = 0; l < 4; l++) begin
         wr(cbc_pkg::REG_DISABLED_OUTPUT_LEVEL, 8'(l));
         check_drive(1'b0);
      end
      out_en_ctrl <= 4'hF;
      check_drive(1'b1);
      // enable pins released: outputs take the disabled level
      oe_n_pin <= 4'hF;
      repeat (6) @(posedge mclk);
      check_drive(1'b0);
      oe_n_pin <= 4'h0;
      // power down keeping the configuration
      wr(cbc_pkg::REG_POWERDOWN_RETENTION, 8'h40);
      wr(cbc_pkg::REG_DISABLED_OUTPUT_LEVEL, 8'h02);
      powergood_pin <= 1'b0;
      repeat (8) @(posedge mclk);
      check({7'h0, powered_up}, 8'h00);
      check_drive(1'b0);
      check_all();
      powergood_pin <= 1'b1;
      repeat (8) @(posedge mclk);
      check({7'h0, powered_up}, 8'h01);
      // power down clearing the configuration
      wr(cbc_pkg::REG_POWERDOWN_RETENTION, 8'h00);
      wr(cbc_pkg::REG_READBACK_LENGTH, 8'h03);
      powergood_pin <= 1'b0;
      repeat (8) @(posedge mclk);
      reset_shadow();
      check_all();
      check_drive(1'b0);
      complete_run();
   end

   initial begin
      #(40 * 4000);
      mismatches++;
      complete_run();
   end
endmodule
`default_nettype wire

/* hdl/cbc_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module cbc_pin_sync #(
   parameter int unsigned  W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // pin side
   input  wire logic [W-1:0] pin_in,
   // filtered level
   output logic      [W-1:0] level_out
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] out_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= RST_VAL;
         s2_ff <= RST_VAL;
         s3_ff <= RST_VAL;
      end else begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_ff <= RST_VAL;
      end else begin
         out_ff <= (s2_ff & s3_ff) | (out_ff & (s2_ff ^ s3_ff));
      end
   end

   assign level_out = out_ff;

endmodule
`default_nettype wire

/* hdl/cbc_regs.sv */
// configuration register bank and output control of the clock buffer
// Notes on behaviour
// RULE1: register 7 bits 4:0 hold read-back byte count, default eight.
// RULE2: register 10 bit 6 keeps config in power down; zero restores.
// RULE3: host leaves register 10 bit 7 at zero; it stays writable.
// RULE4: register 11 bits 1:0 give disabled output true/complement level.
// RULE5: impedance codes 00 is 33, 01 is 85, 10 is 100 ohm.
// RULE6: impedance fields in registers 12 and 13; code 11 is refused.
// RULE7: bias codes none, pull-down, pull-up, both.
// RULE8: enable biases in registers 14, 15 default pull-down; power-good 16.
// RULE9: registers 8, 9 and 17 reserved, read zero, ignore writes.
// RULE10: low enable bit in register 0 forces output to disabled level.
// RULE11: impedance power-up values come from the factory default input.
`timescale 1ns/1ps
`default_nettype none
module cbc_regs (
   // clock and reset
   input  wire logic                        MCLK,
   input  wire logic                        RSTN,
   // register port from the bus engine
   input  wire logic [7:0]                  REG_ADDR,
   input  wire logic                        REG_WR,
   input  wire logic [7:0]                  REG_WDATA,
   output logic      [7:0]                  REG_RDATA,
   // enable bits held in register 0
   input  wire logic [3:0]                  OUT_EN_CTRL,
   // factory default impedance set
   input  wire logic [3:0][1:0]             FACTORY_IMP,
   // device pins
   input  wire logic [3:0]                  OE_N_PIN,
   input  wire logic                        POWERGOOD_PIN,
   // configuration outputs
   output logic      [4:0]                  READBACK_COUNT,
   output logic                             KEEP_CONFIG,
   output logic      [3:0][1:0]             IMPEDANCE_SEL,
   output logic      [4:0]                  PULLUP_EN,
   output logic      [4:0]                  PULLDN_EN,
   output logic                             POWERED_UP,
   output var cbc_pkg::cbc_drive_t [3:0]    DRIVE
);

   logic [4:0]              count_ff;
   logic                    keep_ff;
   logic                    rsvd10_ff;
   logic [1:0]              level_ff;
   logic [3:0][1:0]         imp_ff;
   logic [4:0][1:0]         bias_ff;
   logic                    load_ff;
   logic                    pg_prev_ff;
   logic [7:0]              rdata_ff;
   logic [7:0]              nxt_rdata;
   cbc_pkg::cbc_drive_t [3:0] drive_ff;
   logic [3:0]              oe_n_sync;
   logic                    pg_sync;
   logic                    pd_enter;
   logic                    restore;
   logic                    hw_load;
   logic                    wr_ok;

   // pin synchronisers
   cbc_pin_sync #(
      .W       (4),
      .RST_VAL (4'hF)
   ) u_oe_sync (
      .clk       (MCLK),
      .rst_n     (RSTN),
      .pin_in    (OE_N_PIN),
      .level_out (oe_n_sync)
   );

   cbc_pin_sync #(
      .W       (1),
      .RST_VAL (1'b0)
   ) u_pg_sync (
      .clk       (MCLK),
      .rst_n     (RSTN),
      .pin_in    (POWERGOOD_PIN),
      .level_out (pg_sync)
   );

   // power-down entry and restore of defaults
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         pg_prev_ff <= 1'b0;
      end else begin
         pg_prev_ff <= pg_sync;
      end
   end

   assign pd_enter = pg_prev_ff & ~pg_sync;
   assign restore  = pd_enter & ~keep_ff; // see RULE2
   assign hw_load  = restore | load_ff;
   assign wr_ok    = REG_WR & ~hw_load;

   // factory impedance set is caught once after reset release
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         load_ff <= 1'b1;
      end else begin
         load_ff <= 1'b0;
      end
   end

   // read-back byte count
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         count_ff <= cbc_pkg::COUNT_RST; // see RULE1
      end else if (hw_load) begin
         count_ff <= cbc_pkg::COUNT_RST;
      end else if (wr_ok && REG_ADDR == cbc_pkg::REG_READBACK_LENGTH) begin
         count_ff <=
            REG_WDATA[cbc_pkg::COUNT_LSB +: cbc_pkg::CNT_W]; // see RULE1
      end
   end

   // retention control and its reserved companion bit
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         keep_ff   <= cbc_pkg::KEEP_RST;
         rsvd10_ff <= cbc_pkg::RSVD10_RST;
      end else if (hw_load) begin
         keep_ff   <= cbc_pkg::KEEP_RST;
         rsvd10_ff <= cbc_pkg::RSVD10_RST;
      end else if (wr_ok && REG_ADDR == cbc_pkg::REG_POWERDOWN_RETENTION) begin
         keep_ff   <= REG_WDATA[cbc_pkg::KEEP_BIT]; // see RULE2
         rsvd10_ff <= REG_WDATA[cbc_pkg::RSVD10_BIT]; // see RULE3
      end
   end

   // disabled output level
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         level_ff <= cbc_pkg::LEVEL_RST;
      end else if (hw_load) begin
         level_ff <= cbc_pkg::LEVEL_RST;
      end else if (wr_ok &&
                   REG_ADDR == cbc_pkg::REG_DISABLED_OUTPUT_LEVEL) begin
         level_ff <= REG_WDATA[cbc_pkg::LEVEL_LSB +: 2]; // see RULE4
      end
   end

   // impedance selects; a written reserved code leaves the field alone, a reserved factory code loads IMP_RST; see RULE5
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < 4; i++) begin
            imp_ff[i] <= cbc_pkg::IMP_RST;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (hw_load) begin
               if (FACTORY_IMP[i] != cbc_pkg::IMP_RSVD) begin
                  imp_ff[i] <= FACTORY_IMP[i]; // see RULE11
               end else begin
                  imp_ff[i] <= cbc_pkg::IMP_RST;
               end
            end else if (wr_ok && REG_ADDR == cbc_pkg::IMP_ADDR[i] &&
                         REG_WDATA[cbc_pkg::IMP_LSB[i] +: 2] !=
                         cbc_pkg::IMP_RSVD) begin
               imp_ff[i] <= REG_WDATA[cbc_pkg::IMP_LSB[i] +: 2]; // see RULE6
            end
         end
      end
   end

   // input pin bias selects
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < 5; i++) begin
            bias_ff[i] <= cbc_pkg::BIAS_RST[i]; // see RULE8
         end
      end else begin
         for (int i = 0; i < 5; i++) begin
            if (hw_load) begin
               bias_ff[i] <= cbc_pkg::BIAS_RST[i];
            end else if (wr_ok && REG_ADDR == cbc_pkg::BIAS_ADDR[i]) begin
               bias_ff[i] <= REG_WDATA[cbc_pkg::BIAS_LSB[i] +: 2]; // see RULE8
            end
         end
      end
   end

   // read mux; reserved and unmapped offsets read zero
   always_comb begin
      nxt_rdata = '0;
      if (REG_ADDR == cbc_pkg::REG_READBACK_LENGTH) begin
         nxt_rdata = 8'(count_ff);
      end else if (REG_ADDR == cbc_pkg::REG_POWERDOWN_RETENTION) begin
         nxt_rdata[cbc_pkg::KEEP_BIT]   = keep_ff;
         nxt_rdata[cbc_pkg::RSVD10_BIT] = rsvd10_ff;
      end else if (REG_ADDR == cbc_pkg::REG_DISABLED_OUTPUT_LEVEL) begin
         nxt_rdata[cbc_pkg::LEVEL_LSB +: 2] = level_ff;
      end else if (REG_ADDR == cbc_pkg::REG_RSVD_A ||
                   REG_ADDR == cbc_pkg::REG_RSVD_B ||
                   REG_ADDR == cbc_pkg::REG_RSVD_C) begin
         nxt_rdata = '0; // see RULE9
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (REG_ADDR == cbc_pkg::IMP_ADDR[i]) begin
               nxt_rdata[cbc_pkg::IMP_LSB[i] +: 2] = imp_ff[i]; // see RULE6
            end
         end
         for (int i = 0; i < 5; i++) begin
            if (REG_ADDR == cbc_pkg::BIAS_ADDR[i]) begin
               nxt_rdata[cbc_pkg::BIAS_LSB[i] +: 2] = bias_ff[i];
            end
         end
         if (REG_ADDR == cbc_pkg::REG_POWERGOOD_PIN_BIAS) begin
            nxt_rdata = nxt_rdata | cbc_pkg::RSVD16_VAL;
         end
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         rdata_ff <= cbc_pkg::RDATA_RST;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // output drive state: register 0 bit, pin and power state
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         drive_ff <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (OUT_EN_CTRL[i] && !oe_n_sync[i] && pg_sync) begin
               drive_ff[i] <= '{run: 1'b1, hiz: 1'b0,
                                true_lvl: 1'b0, comp_lvl: 1'b0};
            end else begin
               drive_ff[i].run <= 1'b0; // see RULE10
               drive_ff[i].hiz <= (level_ff == cbc_pkg::LEVEL_HIZ); // see RULE4
               drive_ff[i].true_lvl <=
                  (level_ff == cbc_pkg::LEVEL_HIGH_LOW); // see RULE4
               drive_ff[i].comp_lvl <=
                  (level_ff == cbc_pkg::LEVEL_LOW_HIGH); // see RULE4
            end
         end
      end
   end

   assign REG_RDATA      = rdata_ff;
   assign READBACK_COUNT = count_ff;
   assign KEEP_CONFIG    = keep_ff;
   assign IMPEDANCE_SEL  = imp_ff;
   assign POWERED_UP     = pg_sync;
   assign DRIVE          = drive_ff;

   // bias decode: bit one pulls up, bit zero pulls down
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         PULLUP_EN[i] = bias_ff[i][cbc_pkg::BIAS_PU_BIT]; // see RULE7
         PULLDN_EN[i] = bias_ff[i][cbc_pkg::BIAS_PD_BIT]; // see RULE7
      end
   end

   // checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   logic imp_has_rsvd;
   assign imp_has_rsvd = (imp_ff[0] == cbc_pkg::IMP_RSVD) |
                         (imp_ff[1] == cbc_pkg::IMP_RSVD) |
                         (imp_ff[2] == cbc_pkg::IMP_RSVD) |
                         (imp_ff[3] == cbc_pkg::IMP_RSVD);
   property p_count_write; // see RULE1
      wr_ok && REG_ADDR == cbc_pkg::REG_READBACK_LENGTH
         |=> count_ff == $past(REG_WDATA[4:0]) ##1
             $past(REG_ADDR) != cbc_pkg::REG_READBACK_LENGTH ||
             REG_RDATA[4:0] == $past(count_ff);
   endproperty
   a_count_write: assert property (p_count_write) // see RULE1
      else $error("byte count write not taken");

   property p_restore; // see RULE2
      restore |=> count_ff == cbc_pkg::COUNT_RST &&
                  level_ff == cbc_pkg::LEVEL_RST && keep_ff;
   endproperty
   a_restore: assert property (p_restore) // see RULE2
      else $error("config not restored in power down");

   property p_keep; // see RULE2
      pd_enter && keep_ff && !REG_WR |=> $stable(count_ff) &&
                                        $stable(level_ff);
   endproperty
   a_keep: assert property (p_keep) // see RULE2
      else $error("config lost although retention set");

   property p_override; // see RULE10
      !OUT_EN_CTRL[0] |=> !DRIVE[0].run &&
         DRIVE[0].hiz == ($past(level_ff) == cbc_pkg::LEVEL_HIZ);
   endproperty
   a_override: assert property (p_override) // see RULE10
      else $error("output not forced to disabled state");

   property p_high_low; // see RULE4
      level_ff == cbc_pkg::LEVEL_HIGH_LOW && !OUT_EN_CTRL[1]
         |=> DRIVE[1].true_lvl && !DRIVE[1].comp_lvl && !DRIVE[1].hiz;
   endproperty
   a_high_low: assert property (p_high_low) // see RULE4
      else $error("disabled level high/low wrong");

   property p_imp_85; // see RULE5
      wr_ok && REG_ADDR == cbc_pkg::REG_OUTPUT_IMPEDANCE_A &&
      REG_WDATA[3:2] == cbc_pkg::IMP_85 |=> imp_ff[0] == cbc_pkg::IMP_85;
   endproperty
   a_imp_85: assert property (p_imp_85) // see RULE5
      else $error("impedance write to output 0 lost");

   property p_imp_no_rsvd; // see RULE6
      !imp_has_rsvd;
   endproperty
   a_imp_no_rsvd: assert property (p_imp_no_rsvd) // see RULE6
      else $error("reserved impedance code stored");

   property p_bias_both; // see RULE7
      wr_ok && REG_ADDR == cbc_pkg::REG_POWERGOOD_PIN_BIAS &&
      REG_WDATA[1:0] == cbc_pkg::BIAS_BOTH |=> PULLUP_EN[4] && PULLDN_EN[4];
   endproperty
   a_bias_both: assert property (p_bias_both) // see RULE7
      else $error("power-good bias decode wrong");

   property p_bias_place; // see RULE8
      wr_ok && REG_ADDR == cbc_pkg::REG_ENABLE_PIN_BIAS_B
         |=> bias_ff[3] == $past(REG_WDATA[5:4]) &&
             bias_ff[2] == $past(REG_WDATA[3:2]) && $stable(bias_ff[0]);
   endproperty
   a_bias_place: assert property (p_bias_place) // see RULE8
      else $error("enable bias fields misplaced");

   property p_rsvd_read; // see RULE9
      REG_ADDR == cbc_pkg::REG_RSVD_A || REG_ADDR == cbc_pkg::REG_RSVD_C
         |=> REG_RDATA == 8'h00;
   endproperty
   a_rsvd_read: assert property (p_rsvd_read) // see RULE9
      else $error("reserved register reads non-zero");

   property p_factory; // see RULE11
      load_ff && FACTORY_IMP[2] != cbc_pkg::IMP_RSVD
         |=> IMPEDANCE_SEL[2] == $past(FACTORY_IMP[2]);
   endproperty
   a_factory: assert property (p_factory) // see RULE11
      else $error("factory impedance not loaded");

endmodule
`default_nettype wire

/* inc/cbc_pkg.sv */
// constants and types shared by the clock buffer configuration bank
package cbc_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned N_OUT  = 4;
   localparam int unsigned N_BIAS = 5;
   localparam int unsigned CNT_W  = 5;

   // register offsets
   localparam logic [7:0] REG_READBACK_LENGTH       = 8'h07;
   localparam logic [7:0] REG_RSVD_A                = 8'h08;
   localparam logic [7:0] REG_RSVD_B                = 8'h09;
   localparam logic [7:0] REG_POWERDOWN_RETENTION   = 8'h0A;
   localparam logic [7:0] REG_DISABLED_OUTPUT_LEVEL = 8'h0B;
   localparam logic [7:0] REG_OUTPUT_IMPEDANCE_A    = 8'h0C;
   localparam logic [7:0] REG_OUTPUT_IMPEDANCE_B    = 8'h0D;
   localparam logic [7:0] REG_ENABLE_PIN_BIAS_A     = 8'h0E;
   localparam logic [7:0] REG_ENABLE_PIN_BIAS_B     = 8'h0F;
   localparam logic [7:0] REG_POWERGOOD_PIN_BIAS    = 8'h10;
   localparam logic [7:0] REG_RSVD_C                = 8'h11;

   // field positions
   localparam int unsigned COUNT_LSB  = 0;
   localparam int unsigned KEEP_BIT   = 6;
   localparam int unsigned RSVD10_BIT = 7;
   localparam int unsigned LEVEL_LSB  = 0;
   localparam logic [7:0] IMP_ADDR [4] = '{8'h0C, 8'h0C, 8'h0D, 8'h0D};
   localparam int unsigned IMP_LSB [4] = '{2, 6, 2, 4};
   localparam logic [7:0] BIAS_ADDR [5] =
      '{8'h0E, 8'h0E, 8'h0F, 8'h0F, 8'h10};
   localparam int unsigned BIAS_LSB [5] = '{2, 6, 2, 4, 0};

   // encodings
   localparam logic [1:0] LEVEL_LOW_LOW  = 2'h0;
   localparam logic [1:0] LEVEL_HIZ      = 2'h1;
   localparam logic [1:0] LEVEL_HIGH_LOW = 2'h2;
   localparam logic [1:0] LEVEL_LOW_HIGH = 2'h3;
   localparam logic [1:0] IMP_33         = 2'h0;
   localparam logic [1:0] IMP_85         = 2'h1;
   localparam logic [1:0] IMP_100        = 2'h2;
   localparam logic [1:0] IMP_RSVD       = 2'h3;
   localparam logic [1:0] BIAS_NONE      = 2'h0;
   localparam logic [1:0] BIAS_PDWN      = 2'h1;
   localparam logic [1:0] BIAS_PUP       = 2'h2;
   localparam logic [1:0] BIAS_BOTH      = 2'h3;
   localparam int unsigned BIAS_PU_BIT   = 1;
   localparam int unsigned BIAS_PD_BIT   = 0;

   // reset values
   localparam logic [4:0] COUNT_RST   = 5'h08;
   localparam logic       KEEP_RST    = 1'b1;
   localparam logic       RSVD10_RST  = 1'b0;
   localparam logic [1:0] LEVEL_RST   = LEVEL_LOW_LOW;
   localparam logic [1:0] IMP_RST     = IMP_100;
   localparam logic [1:0] BIAS_RST [5] =
      '{BIAS_PDWN, BIAS_PDWN, BIAS_PDWN, BIAS_PDWN, BIAS_PUP};
   localparam logic [7:0] RSVD16_VAL  = 8'h24;
   localparam logic [7:0] RDATA_RST   = 8'h00;

   // state of one differential output
   typedef struct packed {
      logic run;
      logic hiz;
      logic true_lvl;
      logic comp_lvl;
   } cbc_drive_t;

endpackage
